/* hdl/fsc_map.vh */
// Constants for the flow-through burst SRAM cycle control block.
`ifndef FSC_MAP_VH
`define FSC_MAP_VH

// Array size: address bits kept small so the flip-flop array is practical.
`define FSC_AW                 6
// One byte lane is eight data bits plus its parity bit.
`define FSC_LANE_W             9
`define FSC_LANES_WIDE         4
`define FSC_LANES_NARROW       2
// Burst counter width; four beats per loaded address.
`define FSC_BEAT_W             2
`define FSC_BEAT_ZERO          2'h0
`define FSC_BEAT_STEP          2'h1
// Burst order select levels.
`define FSC_MODE_LINEAR        1'b0
`define FSC_MODE_INTERLEAVED   1'b1
// Write data FIFO geometry.
`define FSC_FIFO_DEPTH         16
`define FSC_FIFO_PW            4
// Clock period and sleep timing, the times in clock periods.
`define FSC_CLK_PERIOD_NS      10
`define FSC_SLEEP_ENTRY_TCYC   2
`define FSC_SLEEP_EXIT_TCYC    2
`define FSC_SLEEP_ENTRY_CYC    ((`FSC_SLEEP_ENTRY_TCYC * `FSC_CLK_PERIOD_NS) / `FSC_CLK_PERIOD_NS)
`define FSC_SLEEP_EXIT_CYC     ((`FSC_SLEEP_EXIT_TCYC * `FSC_CLK_PERIOD_NS) / `FSC_CLK_PERIOD_NS)
// Sleep sequencer states and their reset value.
`define FSC_SL_AWAKE           2'h0
`define FSC_SL_ENTER           2'h1
`define FSC_SL_ASLEEP          2'h2
`define FSC_SL_EXIT            2'h3

`endif

/* hdl/fsc_fifo.v */
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module fsc_fifo #(
  parameter W     = 46,
  parameter DEPTH = 16,
  parameter PW    = 4
) (
  input  wire         i_clk,
  input  wire         i_rst,
  input  wire         i_valid,
  output wire         o_ready,
  input  wire [W-1:0] i_data,
  output wire         o_valid,
  input  wire         i_ready,
  output wire [W-1:0] o_data
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [PW:0]  wr_ptr_q;
  reg [PW:0]  rd_ptr_q;
  wire        full;
  wire        empty;
  wire        push;
  wire        pop;

  // Full when the pointers differ only in the wrap bit.
  assign full    = (wr_ptr_q[PW] != rd_ptr_q[PW]) &&
                   (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
  assign empty   = (wr_ptr_q == rd_ptr_q);
  assign o_ready = ~full;
  assign o_valid = ~empty;
  assign push    = i_valid & ~full;
  assign pop     = i_ready & ~empty;
  assign o_data  = mem[rd_ptr_q[PW-1:0]];

  // Pointer update.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_ptr_q <= {(PW+1){1'b0}};
      rd_ptr_q <= {(PW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + {{PW{1'b0}}, 1'b1};
      if (pop)
        rd_ptr_q <= rd_ptr_q + {{PW{1'b0}}, 1'b1};
    end
  end

  // Storage write, no reset needed on the data.
  always @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr_q[PW-1:0]] <= i_data;
  end

endmodule

/* hdl/fsc_burst.v */
// Burst address sequencer for the two low address bits.
`timescale 1ns/1ps
`include "fsc_map.vh"
module fsc_burst (
  input  wire [1:0] i_start,
  input  wire [1:0] i_beat,
  input  wire       i_burst_mode,
  output wire [1:0] o_low
);

  // Interleaved order XORs the start with the beat count, linear adds.
  assign o_low = (i_burst_mode == `FSC_MODE_INTERLEAVED) ?
                 (i_start ^ i_beat) :
                 (i_start + i_beat);

endmodule

/* hdl/fsc_sram.v */
// Cycle control and storage of a flow-through burst SRAM.
//
// Operation
// - All enables not active on a load deselects; data pins float next.
// - Clock qualify high freezes the burst, pipeline and read state for that edge.
// - Load with enables active and write strobe high begins a read.
// - Load with write strobe low begins a write; data two clocks later.
// - Advance after a read continues the read at the next address.
// - Advance after a write continues the write at the next address.
// - Interleaved order steps the low bits as start XOR beat count.
// - Linear order counts the low bits upward modulo four.
// - Each active-low lane select writes its own nine-bit lane.
// - A write with no lanes selected completes and alters nothing.
// - The write strobe alone decides the access type; lane selects only mask the write.
// - Data pins driven only by the current cycle and the output gate.
// - After reset the device is deselected with data pins floating.
// - Sleep request enters and leaves sleep in two clocks each.
// - Stored contents are kept intact while sleeping.
// - Accesses pending at sleep entry may be dropped.
// - Burst mode low selects linear order, high selects interleaved.
// - One loaded address serves four beats, wrapping in its group.
`timescale 1ns/1ps
`include "fsc_map.vh"
module fsc_sram #(
  parameter LANES = `FSC_LANES_WIDE
) (
  input  wire                         i_clk,
  input  wire                         i_rst,
  input  wire [`FSC_AW-1:0]           i_addr,
  input  wire                         i_ce1_n,
  input  wire                         i_ce2,
  input  wire                         i_ce3_n,
  input  wire                         i_clk_qualify_n,
  input  wire                         i_advance_or_load,
  input  wire                         i_we_n,
  input  wire [LANES-1:0]             i_byte_lane_selects_n,
  input  wire                         i_burst_mode,
  input  wire                         i_oe_n,
  input  wire                         i_sleep_request,
  input  wire [LANES*`FSC_LANE_W-1:0] i_dq,
  output wire [LANES*`FSC_LANE_W-1:0] o_dq,
  output wire                         o_dq_oe_n,
  output reg                          o_sleeping,
  output wire                         o_wr_ready
);

  localparam DW  = LANES * `FSC_LANE_W;
  localparam AW  = `FSC_AW;
  localparam FW  = AW + LANES + DW;
  localparam NW  = 1 << AW;
  // Last count of each sleep phase, cut to the counter width on purpose.
  localparam integer ENTRY_CNT = `FSC_SLEEP_ENTRY_CYC - 1;
  localparam integer EXIT_CNT  = `FSC_SLEEP_EXIT_CYC - 1;
  localparam [1:0] ENTRY_LAST = ENTRY_CNT[1:0];
  localparam [1:0] EXIT_LAST  = EXIT_CNT[1:0];

  // Synchronisers for the two asynchronous inputs.
  reg           oe_s1_q;
  reg           oe_s2_q;
  reg           zz_s1_q;
  reg           zz_s2_q;
  // Sleep sequencer.
  reg [1:0]     sl_state_q;
  reg [1:0]     sl_cnt_q;
  // Burst tracking.
  reg           burst_live_q;
  reg           wr_type_q;
  reg [AW-1:0]  base_q;
  reg [1:0]     beat_q;
  // Two-stage command pipeline for the delayed write data.
  reg           s1_valid_q;
  reg           s1_wr_q;
  reg [AW-1:0]  s1_addr_q;
  reg [LANES-1:0] s1_lanes_q;
  reg           s2_valid_q;
  reg           s2_wr_q;
  reg [AW-1:0]  s2_addr_q;
  reg [LANES-1:0] s2_lanes_q;
  // Read data path.
  reg           rd_q;
  reg [DW-1:0]  rdata_q;
  // Storage array.
  reg [DW-1:0]  mem [0:NW-1];

  wire          awake;
  wire          tick;
  wire          all_ce;
  wire          load;
  wire          issue;
  wire          issue_wr;
  wire          issue_rd;
  wire [1:0]    beat_nxt;
  wire [1:0]    burst_low;
  wire [AW-1:0] cur_addr;
  wire          push;
  wire [FW-1:0] push_data;
  wire          drain_valid;
  wire          drain_ready;
  wire [FW-1:0] drain_data;
  wire [AW-1:0] drain_addr;
  wire [LANES-1:0] drain_lanes;
  wire [DW-1:0] drain_word;
  integer       k;

  // Both asynchronous inputs pass two flip-flops first.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      oe_s1_q <= 1'b1;
      oe_s2_q <= 1'b1;
      zz_s1_q <= 1'b0;
      zz_s2_q <= 1'b0;
    end
    else
    begin
      oe_s1_q <= i_oe_n;
      oe_s2_q <= oe_s1_q;
      zz_s1_q <= i_sleep_request;
      zz_s2_q <= zz_s1_q;
    end
  end

  // Sleep sequencer: two clocks to enter and two clocks to leave.
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sl_state_q <= `FSC_SL_AWAKE;
      sl_cnt_q   <= 2'h0;
      o_sleeping <= 1'b0;
    end
    else
    begin
      case (sl_state_q)
        `FSC_SL_AWAKE:
        begin
          sl_cnt_q <= 2'h0;
          if (zz_s2_q)
            sl_state_q <= `FSC_SL_ENTER;
        end
        `FSC_SL_ENTER:
        begin
          sl_cnt_q <= sl_cnt_q + 2'h1;
          if (sl_cnt_q == ENTRY_LAST)
          begin
            sl_state_q <= `FSC_SL_ASLEEP;
            o_sleeping <= 1'b1;
            sl_cnt_q   <= 2'h0;
          end
        end
        `FSC_SL_ASLEEP:
        begin
          if (!zz_s2_q)
          begin
            sl_state_q <= `FSC_SL_EXIT;
            o_sleeping <= 1'b0;
          end
        end
        `FSC_SL_EXIT:
        begin
          sl_cnt_q <= sl_cnt_q + 2'h1;
          if (sl_cnt_q == EXIT_LAST)
          begin
            sl_state_q <= `FSC_SL_AWAKE;
            sl_cnt_q   <= 2'h0;
          end
        end
        default:
        begin
          sl_state_q <= `FSC_SL_AWAKE;
          sl_cnt_q   <= 2'h0;
          o_sleeping <= 1'b0;
        end
      endcase
    end
  end

  // An edge counts only when qualified and the device is fully awake.
  assign awake    = (sl_state_q == `FSC_SL_AWAKE);
  assign tick     = ~i_clk_qualify_n & awake;
  assign all_ce   = ~i_ce1_n & i_ce2 & ~i_ce3_n;
  assign load     = ~i_advance_or_load;

  // Access decode: a load needs every enable, an advance a live burst.
  assign issue    = tick & (load ? all_ce : burst_live_q);
  assign issue_wr = load ? ~i_we_n : wr_type_q;
  assign issue_rd = issue & ~issue_wr;

  // Next beat wraps inside the aligned group of four.
  assign beat_nxt = beat_q + `FSC_BEAT_STEP;

  fsc_burst u_burst (
    .i_start      (base_q[1:0]),
    .i_beat       (beat_nxt),
    .i_burst_mode (i_burst_mode),
    .o_low        (burst_low)
  );

  // Loads use the pins; advances keep the upper bits and step the low bits.
  assign cur_addr = load ? i_addr : {base_q[AW-1:2], burst_low};

  // Burst tracking, frozen on suspended edges and cleared by sleep.
  always @(posedge i_clk)
  begin
    if (i_rst || (sl_state_q == `FSC_SL_ENTER))
    begin
      burst_live_q <= 1'b0;
      wr_type_q    <= 1'b0;
      base_q       <= {AW{1'b0}};
      beat_q       <= `FSC_BEAT_ZERO;
    end
    else if (tick)
    begin
      if (load)
      begin
        burst_live_q <= all_ce;
        base_q       <= i_addr;
        beat_q       <= `FSC_BEAT_ZERO;
        wr_type_q    <= ~i_we_n;
      end
      else if (burst_live_q)
      begin
        // The start stays loaded; only the beat count steps.
        beat_q <= beat_nxt;
      end
    end
  end

  // Command pipeline; the write data is taken two counted edges later.
  always @(posedge i_clk)
  begin
    if (i_rst || !awake)
    begin
      s1_valid_q <= 1'b0;
      s1_wr_q    <= 1'b0;
      s1_addr_q  <= {AW{1'b0}};
      s1_lanes_q <= {LANES{1'b0}};
      s2_valid_q <= 1'b0;
      s2_wr_q    <= 1'b0;
      s2_addr_q  <= {AW{1'b0}};
      s2_lanes_q <= {LANES{1'b0}};
    end
    else if (tick)
    begin
      s1_valid_q <= issue;
      s1_wr_q    <= issue_wr;
      s1_addr_q  <= cur_addr;
      s1_lanes_q <= ~i_byte_lane_selects_n;
      s2_valid_q <= s1_valid_q;
      s2_wr_q    <= s1_wr_q;
      s2_addr_q  <= s1_addr_q;
      s2_lanes_q <= s1_lanes_q;
    end
  end

  // Capture the write beat into the FIFO, even when no lane is selected.
  assign push      = tick & s2_valid_q & s2_wr_q;
  assign push_data = {s2_addr_q, s2_lanes_q, i_dq};

  fsc_fifo #(
    .W     (FW),
    .DEPTH (`FSC_FIFO_DEPTH),
    .PW    (`FSC_FIFO_PW)
  ) u_wr_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (push),
    .o_ready (o_wr_ready),
    .i_data  (push_data),
    .o_valid (drain_valid),
    .i_ready (drain_ready),
    .o_data  (drain_data)
  );

  // The single array port serves a read first; nothing drains in sleep.
  assign drain_ready = ~issue_rd & ~o_sleeping;
  assign drain_addr  = drain_data[FW-1 -: AW];
  assign drain_lanes = drain_data[DW +: LANES];
  assign drain_word  = drain_data[DW-1:0];

  // Lane-masked array write; unselected lanes keep their contents.
  always @(posedge i_clk)
  begin
    if (drain_valid && drain_ready)
    begin
      for (k = 0; k < LANES; k = k + 1)
      begin
        if (drain_lanes[k])
          mem[drain_addr][k*`FSC_LANE_W +: `FSC_LANE_W] <=
            drain_word[k*`FSC_LANE_W +: `FSC_LANE_W];
      end
    end
  end

  // Read data is registered at the access edge and held until the next.
  always @(posedge i_clk)
  begin
    if (i_rst || !awake)
    begin
      rd_q    <= 1'b0;
      rdata_q <= {DW{1'b0}};
    end
    else if (tick)
    begin
      rd_q <= issue_rd;
      if (issue_rd)
        rdata_q <= mem[cur_addr];
    end
  end

  // Pins drive only during a read cycle with the output gate low.
  assign o_dq      = rdata_q;
  assign o_dq_oe_n = ~(rd_q & ~oe_s2_q);

endmodule

/* sim/fsc_ctrl_model.sv */
// Memory controller model supplying write data and read markers.
`timescale 1ns/1ps
module fsc_ctrl_model (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_qn,
  input  wire        i_adv,
  input  wire        i_ce,
  input  wire        i_we_n,
  input  wire [35:0] i_wd,
  output wire [35:0] o_dq,
  output reg         o_rd
);
  reg        act_q;
  reg        wr_q;
  reg [36:0] s1_q;
  reg [36:0] s2_q;
  reg [35:0] last_q = 36'h0_0000_0000;
  wire       ld = !i_adv;
  wire       bw = ld ? (i_ce && !i_we_n) : (act_q && wr_q);
  wire       br = ld ? (i_ce && i_we_n) : (act_q && !wr_q);

  // Idle data lines show a changing pattern, never the last word.
  assign o_dq = s2_q[36] ? s2_q[35:0] : ~last_q;

  // Burst type is kept from each load; data waits two counted edges.
  always @(posedge i_clk)
  begin
    last_q <= o_dq;
    o_rd <= !i_rst && !i_qn && br;
    if (i_rst)
    begin
      act_q <= 1'b0;
      s1_q <= 37'h0_0000_0000;
      s2_q <= 37'h0_0000_0000;
    end
    else if (!i_qn)
    begin
      act_q <= ld ? i_ce : act_q;
      wr_q <= ld ? !i_we_n : wr_q;
      s1_q <= {bw, i_wd};
      s2_q <= s1_q;
    end
  end
endmodule

/* sim/fsc_sram_assertions.sv */
// Concurrent checks on the cycle control ports.
`timescale 1ns/1ps
`include "fsc_map.vh"
module fsc_sram_assertions #(
  parameter LANES = `FSC_LANES_WIDE
) (
  input wire                         i_clk,
  input wire                         i_rst,
  input wire                         i_ce1_n,
  input wire                         i_ce2,
  input wire                         i_ce3_n,
  input wire                         i_clk_qualify_n,
  input wire                         i_advance_or_load,
  input wire                         i_we_n,
  input wire                         i_oe_n,
  input wire                         i_sleep_request,
  input wire [LANES*`FSC_LANE_W-1:0] o_dq,
  input wire                         o_dq_oe_n,
  input wire                         o_sleeping,
  input wire                         o_wr_ready
);
  wire on = !i_ce1_n && i_ce2 && !i_ce3_n;
  wire ld = !i_clk_qualify_n && !o_sleeping && !i_advance_or_load;
  wire adv = !i_clk_qualify_n && !o_sleeping && i_advance_or_load;
  wire rd = ld && on && i_we_n && !i_oe_n;
  wire wr = ld && on && !i_we_n;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_RESET: assert property (
    $past(i_rst) |-> o_dq_oe_n && !o_sleeping && o_wr_ready)
    else $error("outputs not idle after reset");
  AST_DESEL: assert property (
    ld && !on |=> o_dq_oe_n)
    else $error("pins driven after deselect");
  AST_SUSP: assert property (
    i_clk_qualify_n |=> $stable(o_dq) && $stable(o_dq_oe_n))
    else $error("state moved on suspended edge");
  AST_READ: assert property (
    rd && !$past(i_oe_n) && !$past(i_rst) |=> !o_dq_oe_n)
    else $error("read not driven");
  AST_WRITE: assert property (
    wr |=> o_dq_oe_n)
    else $error("pins driven on write");
  AST_RBURST: assert property (
    rd && !$past(i_rst, 2) ##1 adv |=> !o_dq_oe_n)
    else $error("read burst not driven");
  AST_WBURST: assert property (
    wr ##1 adv |=> o_dq_oe_n)
    else $error("pins driven in write burst");
  AST_SLEEP_IN: assert property (
    $rose(i_sleep_request) |-> !o_sleeping [*3] ##[1:3] o_sleeping)
    else $error("sleep entry timing");
  AST_SLEEP_OUT: assert property (
    $fell(i_sleep_request) |-> o_sleeping [*3] ##[1:3] !o_sleeping)
    else $error("sleep exit timing");
  AST_SLEEP_SYNC: assert property (
    $rose(o_sleeping) |-> $past(i_sleep_request, 3))
    else $error("sleep before synchronised");
  AST_SLEEP_FLOAT: assert property (
    o_sleeping |-> o_dq_oe_n)
    else $error("pins driven asleep");
  // A raised output gate floats the pins once it has passed the sync.
  AST_GATE_OFF: assert property (
    $past(i_oe_n) |=> o_dq_oe_n)
    else $error("pins driven with gate high");
endmodule

bind fsc_sram fsc_sram_assertions #(.LANES(LANES)) u_chk (.i_clk(i_clk),
  .i_rst(i_rst), .i_ce1_n(i_ce1_n), .i_ce2(i_ce2), .i_ce3_n(i_ce3_n),
  .i_clk_qualify_n(i_clk_qualify_n), .i_advance_or_load(i_advance_or_load),
  .i_we_n(i_we_n), .i_oe_n(i_oe_n), .i_sleep_request(i_sleep_request),
  .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .o_sleeping(o_sleeping),
  .o_wr_ready(o_wr_ready));

/* sim/tb.sv */
// Self-checking bench for the burst SRAM cycle control.
`timescale 1ns/1ps
module tb;
  reg         i_clk = 1'b0;
  reg         i_rst = 1'b1;
  reg  [5:0]  addr = 6'h00;
  reg  [5:0]  ba = 6'h00;
  reg  [2:0]  ce = 3'h0;
  reg         qn = 1'b1;
  reg         adv = 1'b0;
  reg         we_n = 1'b1;
  reg  [3:0]  sel = 4'h0;
  reg         mode = 1'b0;
  reg         slp = 1'b0;
  reg         oe_n = 1'b0;
  reg  [35:0] wd = 36'h0_0000_0000;
  reg  [31:0] rs = 32'h853b_c076;
  reg  [35:0] mem [0:63];
  reg  [35:0] q [$];
  integer     miscompares = 0;
  integer     check_count = 0;
  integer     i;
  wire [35:0] dq_in;
  wire [35:0] o_dq;
  wire        o_dq_oe_n;
  wire        o_sleeping;
  wire        o_wr_ready;
  wire        rd;

  // Clock of 100 MHz.
  always #5 i_clk = !i_clk;

  fsc_sram uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_ce1_n(ce[0]),
    .i_ce2(ce[1]), .i_ce3_n(ce[2]), .i_clk_qualify_n(qn),
    .i_advance_or_load(adv), .i_we_n(we_n), .i_byte_lane_selects_n(sel),
    .i_burst_mode(mode), .i_oe_n(oe_n), .i_sleep_request(slp), .i_dq(dq_in),
    .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n), .o_sleeping(o_sleeping),
    .o_wr_ready(o_wr_ready));

  fsc_ctrl_model ctl (.i_clk(i_clk), .i_rst(i_rst), .i_qn(qn), .i_adv(adv),
    .i_ce(ce == 3'h2), .i_we_n(we_n), .i_wd(wd), .o_dq(dq_in), .o_rd(rd));

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task tally_and_finish;
    begin
      if (miscompares == 0 && check_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  task chk_bit(input a, input e);
    begin
      check_count = check_count + 1;
      if (a !== e)
      begin
        miscompares = miscompares + 1;
        $display("Error %0t flag %b expected %b", $time, a, e);
      end
    end
  endtask

  // With the gate high only floating pins are expected.
  task chk_rd(input [35:0] e, input g);
    begin
      check_count = check_count + 1;
      if (g ? (o_dq_oe_n !== 1'b1) : (o_dq !== e || o_dq_oe_n !== 1'b0))
      begin
        miscompares = miscompares + 1;
        $display("Error %0t read %h expected %h", $time, o_dq, e);
      end
    end
  endtask

  // One bus beat, launched just after a rising edge.
  task beat(input q1, input a, input [2:0] c, input w, input [3:0] s,
            input [5:0] ad);
    begin
      qn = q1;
      adv = a;
      ce = c;
      we_n = w;
      sel = s;
      addr = ad;
      rs = lfsr(rs);
      wd = {rs[7:4], rs};
      @(posedge i_clk);
      #1;
    end
  endtask

  // Deselect beats with ce2 inactive and the rest random.
  task idle(input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1)
        beat(1'b0, 1'b0, {rs[2], 1'b0, rs[0]}, rs[3], rs[7:4], rs[13:8]);
    end
  endtask

  // Four-beat burst with random suspends; selects random unless forced.
  task burst(input w, input m, input [5:0] a0, input [4:0] sm);
    integer b;
    integer k;
    reg [5:0] a;
    begin
      mode = m;
      for (b = 0; b < 4; b = b + 1)
      begin
        a = {a0[5:2], m ? a0[1:0] ^ b[1:0] : a0[1:0] + b[1:0]};
        if (rs[5])
          beat(1'b1, rs[6], rs[9:7], rs[10], rs[14:11], rs[20:15]);
        beat(1'b0, b != 0, b ? rs[2:0] : 3'h2, b ? rs[3] : !w,
             sm[4] ? sm[3:0] : rs[19:16], b ? rs[25:20] : a0);
        for (k = 0; k < 4; k = k + 1)
          if (w && !sel[k])
            mem[a][9*k+:9] = wd[9*k+:9];
        if (!w)
          q.push_back(mem[a]);
      end
    end
  endtask

  task wait_sleep(input e);
    integer k;
    begin
      for (k = 0; k < 12 && o_sleeping !== e; k = k + 1)
        idle(1);
      chk_bit(o_sleeping, e);
      if (o_sleeping !== e)
        tally_and_finish;
    end
  endtask

  // Each read result is matched with the oldest expected word.
  always @(negedge i_clk)
    if (rd === 1'b1)
    begin
      if (q.size() == 0)
        chk_bit(1'b1, 1'b0);
      else
        chk_rd(q.pop_front(), oe_n);
    end

  // Main sequence: fill, burst pairs, sleep, read back.
  initial
  begin
    repeat (8) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    chk_bit(o_dq_oe_n, 1'b1);
    chk_bit(o_sleeping, 1'b0);
    chk_bit(o_wr_ready, 1'b1);
    for (i = 0; i < 64; i = i + 4)
      burst(1'b1, 1'b0, i[5:0], 5'h10);
    idle(4);
    for (i = 0; i < 16; i = i + 1)
    begin
      ba = {rs[31:28], i[1:0]};
      burst(1'b1, i[2], ba, i[3] ? 5'h1f : 5'h00);
      idle(4);
      burst(1'b0, i[2], ba, 5'h00);
    end
    idle(2);
    slp = 1'b1;
    wait_sleep(1'b1);
    idle(4);
    slp = 1'b0;
    wait_sleep(1'b0);
    idle(3);
    for (i = 0; i < 64; i = i + 4)
      burst(1'b0, 1'b1, i[5:0], 5'h00);
    idle(4);
    oe_n = 1'b1;
    idle(3);
    burst(1'b0, 1'b0, 6'h05, 5'h00);
    idle(1);
    oe_n = 1'b0;
    idle(4);
    chk_bit(q.size() == 0, 1'b1);
    chk_bit(o_wr_ready, 1'b1);
    tally_and_finish;
  end
endmodule
